// [core/pmq_top.v]
// digital processing of the pir motion qualifier: start-up, deglitch, recognition
`timescale 1ns/1ps
`default_nettype none
`include "pmq_regs.vh"

module pmq_top #(
   parameter [31:0] TICK_CYC = `PMQ_TICK_CYC
) (
   // clock and reset
   input wire mclk,
   input wire rst,
   // window comparator flags
   input wire comp_hi,
   input wire comp_lo,
   // straps
   input wire mode,
   input wire indicator_enable_n,
   // outputs
   output reg detect_ff,
   output reg indicator_ff,
   output reg startup_ff
);

   // ----------------------------------------------------------------------------
   // states
   // ----------------------------------------------------------------------------
   localparam [2:0] ST_START = 3'h1;
   localparam [2:0] ST_IDLE = 3'h2;
   localparam [2:0] ST_WAIT = 3'h4;

   localparam [31:0] STARTUP_N = `PMQ_STARTUP_TICKS - 1;
   localparam [31:0] BLINK_N = `PMQ_BLINK_TICKS - 1;
   localparam [31:0] WIN_N = `PMQ_DUAL_WIN_TICKS - 1;
   localparam [31:0] HOLD_N = `PMQ_DET_HOLD_TICKS - 1;
   localparam [10:0] STARTUP_LAST = STARTUP_N[10:0];
   localparam [10:0] BLINK_LAST = BLINK_N[10:0];
   localparam [10:0] WIN_LAST = WIN_N[10:0];
   localparam [10:0] HOLD_LAST = HOLD_N[10:0];
   localparam [31:0] TICK_LAST = TICK_CYC - 32'h1;

   // ----------------------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------------------
   wire [`PMQ_IN_W-1:0] raw_in;
   wire [`PMQ_IN_W-1:0] sync_in;

   // the analog comparator already produces the two flags [R1]
   assign raw_in[`PMQ_IN_HI] = comp_hi;
   assign raw_in[`PMQ_IN_LO] = comp_lo;
   assign raw_in[`PMQ_IN_MODE] = mode;
   assign raw_in[`PMQ_IN_LEDEN_N] = indicator_enable_n;

   genvar gi;
   generate
      for (gi = 0; gi < `PMQ_IN_W; gi = gi + 1) begin : g_sync
         // one flop pair per bit keeps every register in a single process
         reg meta_ff;
         reg sync_ff;
         always @(posedge mclk) begin
            if (rst) begin
               meta_ff <= 1'b0;
               sync_ff <= 1'b0;
            end else begin
               meta_ff <= raw_in[gi]; // [R14]
               sync_ff <= meta_ff; // [R14]
            end
         end
         assign sync_in[gi] = sync_ff;
      end
   endgenerate

   // ----------------------------------------------------------------------------
   // system tick
   // ----------------------------------------------------------------------------
   // every duration is counted in ticks of the nominal system oscillator, so
   // shortening TICK_CYC scales all of them together [R2]
   reg [31:0] tick_cnt_ff;
   reg tick_ff;

   always @(posedge mclk) begin
      if (rst) begin
         tick_cnt_ff <= 32'h0;
         tick_ff <= 1'b0;
      end else if (tick_cnt_ff >= TICK_LAST) begin
         tick_cnt_ff <= 32'h0;
         tick_ff <= 1'b1; // [R2] [R3]
      end else begin
         tick_cnt_ff <= tick_cnt_ff + 32'h1;
         tick_ff <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------------
   // deglitch stages
   // ----------------------------------------------------------------------------
   wire [1:0] acc;

   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_dgl
         pmq_deglitch u_dgl (
            .mclk(mclk),
            .rst(rst),
            .tick(tick_ff),
            .flag(sync_in[gi]),
            .accept_ff(acc[gi])
         );
      end
   endgenerate

   // ----------------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------------
   // true when a pulse of the opposite polarity to the pending one arrived
   function opp_hit;
      input pend_hi;
      input [1:0] a;
      begin
         opp_hit = pend_hi ? a[`PMQ_IN_LO] : a[`PMQ_IN_HI];
      end
   endfunction

   // ----------------------------------------------------------------------------
   // recognition state machine
   // ----------------------------------------------------------------------------
   reg [2:0] state_ff;
   reg [2:0] nxt_state;
   reg [10:0] cnt_ff;
   reg [10:0] nxt_cnt;
   reg [10:0] blink_ff;
   reg [10:0] nxt_blink;
   reg pend_hi_ff;
   reg nxt_pend_hi;
   reg trig;

   always @* begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_blink = blink_ff;
      nxt_pend_hi = pend_hi_ff;
      trig = 1'b0;
      case (state_ff)
         ST_START: begin
            // pulses arriving now are simply dropped [R4] [R6]
            if (tick_ff) begin
               nxt_blink = (blink_ff == BLINK_LAST) ? 11'h0 : blink_ff + 11'h1;
               if (cnt_ff == STARTUP_LAST) begin
                  nxt_state = ST_IDLE; // [R4]
                  nxt_cnt = 11'h0;
               end else begin
                  nxt_cnt = cnt_ff + 11'h1;
               end
            end
         end
         ST_IDLE: begin
            if (!sync_in[`PMQ_IN_MODE]) begin
               trig = |acc; // [R9]
            end else if (acc == 2'h3) begin
               trig = 1'b1; // [R10]
            end else if (|acc) begin
               nxt_state = ST_WAIT; // [R10]
               nxt_pend_hi = acc[`PMQ_IN_HI];
               nxt_cnt = 11'h0;
            end
         end
         ST_WAIT: begin
            if (!sync_in[`PMQ_IN_MODE]) begin
               // leaving dual mode drops the pending pulse
               nxt_state = ST_IDLE;
               trig = |acc; // [R9]
            end else if (opp_hit(pend_hi_ff, acc)) begin
               trig = 1'b1; // [R10]
               nxt_state = ST_IDLE;
            end else if (|acc) begin
               // a repeat of the same flag starts a fresh window
               nxt_cnt = 11'h0;
            end else if (tick_ff) begin
               if (cnt_ff == WIN_LAST) begin
                  nxt_state = ST_IDLE; // [R11]
               end else begin
                  nxt_cnt = cnt_ff + 11'h1;
               end
            end
         end
         default: begin
            nxt_state = ST_START;
            nxt_cnt = 11'h0;
            nxt_blink = 11'h0;
         end
      endcase
   end

   always @(posedge mclk) begin
      if (rst) begin
         state_ff <= ST_START; // [R15]
         cnt_ff <= 11'h0; // [R15]
         blink_ff <= 11'h0;
         pend_hi_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         blink_ff <= nxt_blink;
         pend_hi_ff <= nxt_pend_hi;
      end
   end

   // ----------------------------------------------------------------------------
   // detect output
   // ----------------------------------------------------------------------------
   // a new trigger during the hold restarts it, so a stream of motion keeps
   // the output high instead of chattering
   reg [10:0] hold_ff;
   reg [10:0] nxt_hold;
   reg nxt_detect;

   always @* begin
      nxt_hold = hold_ff;
      nxt_detect = detect_ff;
      if (state_ff == ST_START) begin
         nxt_detect = 1'b0; // [R6]
         nxt_hold = 11'h0;
      end else if (trig) begin
         nxt_detect = 1'b1; // [R9] [R10]
         nxt_hold = 11'h0;
      end else if (detect_ff && tick_ff) begin
         if (hold_ff == HOLD_LAST) begin
            nxt_detect = 1'b0;
         end else begin
            nxt_hold = hold_ff + 11'h1;
         end
      end
   end

   always @(posedge mclk) begin
      if (rst) begin
         detect_ff <= 1'b0; // [R6]
         hold_ff <= 11'h0;
      end else begin
         detect_ff <= nxt_detect;
         hold_ff <= nxt_hold;
      end
   end

   // ----------------------------------------------------------------------------
   // indicator and start-up flag
   // ----------------------------------------------------------------------------
   reg nxt_indicator;

   always @* begin
      nxt_indicator = indicator_ff;
      if (state_ff == ST_START) begin
         // enable strap is ignored while starting up [R5]
         if (tick_ff && blink_ff == BLINK_LAST) begin
            nxt_indicator = ~indicator_ff; // [R5]
         end
         if (tick_ff && cnt_ff == STARTUP_LAST) begin
            nxt_indicator = 1'b0;
         end
      end else if (trig && !sync_in[`PMQ_IN_LEDEN_N]) begin
         nxt_indicator = ~indicator_ff; // [R13]
      end else begin
         nxt_indicator = indicator_ff; // [R12]
      end
   end

   always @(posedge mclk) begin
      if (rst) begin
         indicator_ff <= 1'b0;
         startup_ff <= 1'b1; // [R15]
      end else begin
         indicator_ff <= nxt_indicator;
         startup_ff <= (nxt_state == ST_START);
      end
   end

endmodule // pmq_top
`default_nettype wire

// [core/pmq_regs.vh]
// timing constants and field positions of the pir motion qualifier
//
// Operation
// R1: high-trip flag while amp output above upper threshold, low-trip while below lower.
// R2: all durations and counts are dimensioned for a 62.5 Hz system tick.
// R3: all processing runs synchronous to the system tick; deglitch depends on phase.
// R4: after reset a thirty second start-up sequence precedes any detection.
// R5: during start-up the indicator toggles near two hertz, ignoring indicator enable.
// R6: during start-up the detect output is held low regardless of comparator flags.
// R7: comparator pulses shorter than two tick periods are rejected as glitches.
// R8: comparator pulses longer than three tick periods are always accepted.
// R9: mode low: any deglitched pulse from either flag triggers detect output.
// R10: mode high: opposite-flag pulses within five seconds of each other trigger detect.
// R11: mode high: missing second pulse within timeout discards the pending pulse.
// R12: outside start-up, indicator enable high keeps indicator from toggling on detection.
// R13: outside start-up, indicator enable low toggles indicator on each detection.
// R14: flags, mode and indicator enable pass a two-stage synchronizer first.
// R15: reset release clears all recognition state and restarts start-up.
`ifndef PMQ_REGS_VH
`define PMQ_REGS_VH

// ----------------------------------------------------------------------------
// clock rates
// ----------------------------------------------------------------------------
`define PMQ_MCLK_PERIOD_NS 5
`define PMQ_SYS_PERIOD_US 16000
`define PMQ_TICK_CYC ((`PMQ_SYS_PERIOD_US * 1000) / `PMQ_MCLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// durations in milliseconds and their tick counts
// ----------------------------------------------------------------------------
`define PMQ_STARTUP_MS 30000
`define PMQ_STARTUP_TICKS ((`PMQ_STARTUP_MS * 1000) / `PMQ_SYS_PERIOD_US)
`define PMQ_BLINK_HALF_MS 250
`define PMQ_BLINK_TICKS ((`PMQ_BLINK_HALF_MS * 1000) / `PMQ_SYS_PERIOD_US)
`define PMQ_DUAL_WIN_MS 5000
`define PMQ_DUAL_WIN_TICKS ((`PMQ_DUAL_WIN_MS * 1000) / `PMQ_SYS_PERIOD_US)
`define PMQ_DET_HOLD_MS 2000
`define PMQ_DET_HOLD_TICKS ((`PMQ_DET_HOLD_MS * 1000) / `PMQ_SYS_PERIOD_US)
`define PMQ_DGL_SAMPLES 3

// ----------------------------------------------------------------------------
// synchronised input vector positions
// ----------------------------------------------------------------------------
`define PMQ_IN_HI 0
`define PMQ_IN_LO 1
`define PMQ_IN_MODE 2
`define PMQ_IN_LEDEN_N 3
`define PMQ_IN_W 4

`endif

// [core/pmq_deglitch.v]
// deglitch filter for one comparator flag, sampled on the system tick
`timescale 1ns/1ps
`default_nettype none
`include "pmq_regs.vh"

module pmq_deglitch (
   // clock and reset
   input wire mclk,
   input wire rst,
   // sampling strobe and flag
   input wire tick,
   input wire flag,
   // one-cycle accept strobe
   output reg accept_ff
);

   reg [1:0] run_ff;
   reg [1:0] nxt_run;
   reg nxt_accept;

   localparam [31:0] DGL_N = `PMQ_DGL_SAMPLES - 1;
   localparam [1:0] DGL_LAST = DGL_N[1:0];

   // ----------------------------------------------------------------------------
   // count consecutive high samples
   // ----------------------------------------------------------------------------
   // three samples at tick spacing reject anything under two periods and take
   // anything over three, whatever the phase of the flag edges [R3] [R7] [R8]
   always @* begin
      nxt_run = run_ff;
      nxt_accept = 1'b0;
      if (tick) begin
         if (!flag) begin
            nxt_run = 2'h0;
         end else if (run_ff != 2'h3) begin
            nxt_run = run_ff + 2'h1;
            nxt_accept = (run_ff == DGL_LAST); // [R7] [R8]
         end
      end
   end

   always @(posedge mclk) begin
      if (rst) begin
         run_ff <= 2'h0;
         accept_ff <= 1'b0;
      end else begin
         run_ff <= nxt_run;
         accept_ff <= nxt_accept;
      end
   end

endmodule // pmq_deglitch
`default_nettype wire

// [verif/pmq_comp_model.sv]
// behavioural window comparator ahead of the qualifier
`timescale 1ns/1ps
`default_nettype none
module pmq_comp_model #(
   parameter int UPPER_THRESHOLD_MV = 2500,
   parameter int LOWER_THRESHOLD_MV = 1700
) (
   // amplifier level in millivolts
   input wire logic [11:0] second_amp_output,
   // trip flags
   output logic comp_hi,
   output logic comp_lo
);
   assign comp_hi = (second_amp_output > UPPER_THRESHOLD_MV);
   assign comp_lo = (second_amp_output < LOWER_THRESHOLD_MV);
endmodule // pmq_comp_model
`default_nettype wire

// [verif/pmq_top_properties.sv]
// concurrent checks on the ports of the motion qualifier
`timescale 1ns/1ps
`default_nettype none
module pmq_properties #(
   parameter [31:0] TICK_CYC = 32'd4
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // inputs
   input wire logic comp_hi,
   input wire logic comp_lo,
   input wire logic mode,
   input wire logic indicator_enable_n,
   // outputs
   input wire logic detect_ff,
   input wire logic indicator_ff,
   input wire logic startup_ff
);
   // ----
   // run and age counters
   // ----
   localparam int LONG = 2 * TICK_CYC;
   localparam int FIRE = 3 * TICK_CYC + 6;
   localparam int SU_MIN = 1874 * TICK_CYC;
   localparam int SU_MAX = 1876 * TICK_CYC + 2;
   localparam int BLINK_MAX = 17 * TICK_CYC;
   int hi_run, lo_run, ok_age, su_cnt, post_cnt, md_run, en_run, blink_age;
   always @(posedge mclk) begin
      hi_run <= comp_hi ? hi_run + 1 : 0;
      lo_run <= comp_lo ? lo_run + 1 : 0;
      ok_age <= (hi_run >= LONG || lo_run >= LONG) ? 0 : ok_age + 1;
      su_cnt <= rst ? 0 : su_cnt + int'(startup_ff);
      post_cnt <= (rst || startup_ff) ? 0 : post_cnt + 1;
      md_run <= mode ? 0 : md_run + 1;
      en_run <= indicator_enable_n ? en_run + 1 : 0;
      blink_age <= (rst || $changed(indicator_ff)) ? 0 : blink_age + 1;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // ----
   // properties
   // ----
   a_startup_quiet: assert property (startup_ff |-> !detect_ff)
      else $error("detect during start-up");
   a_reset_state: assert property (disable iff (1'b0) rst |=> startup_ff && !detect_ff)
      else $error("reset state wrong");
   a_startup_len: assert property ($fell(startup_ff) |-> su_cnt inside {[SU_MIN:SU_MAX]})
      else $error("start-up length wrong");
   a_blink_gap: assert property (startup_ff && $changed(indicator_ff) |=> $stable(indicator_ff) [*8])
      else $error("blink too fast");
   a_blink_alive: assert property (startup_ff |-> blink_age <= BLINK_MAX)
      else $error("blink too slow");
   a_glitch_reject: assert property ($rose(detect_ff) |-> ok_age <= 8)
      else $error("detect without a long pulse");
   a_single_fire: assert property ((hi_run == FIRE || lo_run == FIRE) && post_cnt > FIRE
      && md_run > FIRE |-> detect_ff) else $error("long pulse missed");
   a_detect_hold: assert property ($rose(detect_ff) |=> detect_ff [*8])
      else $error("detect pulse too short");
   a_led_still: assert property (!startup_ff && !$past(startup_ff) && en_run > 4
      |-> $stable(indicator_ff)) else $error("indicator moved while disabled");
   c_single: cover property (!mode && $rose(detect_ff));
   c_dual: cover property (mode && $rose(detect_ff));
   c_end: cover property ($fell(startup_ff));
endmodule // pmq_properties
bind pmq_top pmq_properties #(.TICK_CYC(TICK_CYC)) u_pmq_props (
   .mclk(mclk), .rst(rst), .comp_hi(comp_hi), .comp_lo(comp_lo), .mode(mode),
   .indicator_enable_n(indicator_enable_n), .detect_ff(detect_ff),
   .indicator_ff(indicator_ff), .startup_ff(startup_ff)
);
`default_nettype wire

// [verif/pir_motion_qualifier_test.sv]
// self-checking bench of the motion qualifier with a comparator model
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin error_cnt++; \
   $display("mismatch %s exp %0h got %0h", n, e, s); end end
module pir_motion_qualifier_test;
   localparam int T = 4;
   localparam int LIMIT = 40000;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic mode = 1'b0;
   logic indicator_enable_n = 1'b0;
   logic [11:0] amp = 12'h834;
   logic [31:0] seed = 32'h155BD;
   logic exp_ind = 1'b0;
   logic exp_q[$];
   logic got_ind;
   logic ind_d;
   wire c_hi, c_lo, detect, indicator, startup;
   int error_cnt = 0;
   int checks_done = 0;
   int cyc = 0;
   int blinks = 0;
   pmq_comp_model cmp (.second_amp_output(amp), .comp_hi(c_hi), .comp_lo(c_lo));
   pmq_top #(.TICK_CYC(T)) dut (.mclk(mclk), .rst(rst), .comp_hi(c_hi), .comp_lo(c_lo),
      .mode(mode), .indicator_enable_n(indicator_enable_n), .detect_ff(detect),
      .indicator_ff(indicator), .startup_ff(startup));
   initial forever #2.5 mclk = ~mclk;
   // ----
   // helpers
   // ----
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic pulse(input logic up, input int len);
      amp <= up ? 12'hAF0 : 12'h5DC;
      idle(len);
      amp <= 12'h800 + 12'(rnd() % 256);
      idle(1);
   endtask
   task automatic expect_hit();
      if (!indicator_enable_n) exp_ind = !exp_ind;
      exp_q.push_back(exp_ind);
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ----
   // output watcher and timeout
   // ----
   initial forever begin
      @(posedge detect);
      @(posedge mclk);
      #1;
      if (exp_q.size() == 0) begin
         `CHK("unexpected detect", 1'b0, 1'b1)
      end else begin
         got_ind = exp_q.pop_front();
         `CHK("indicator", got_ind, indicator)
      end
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      ind_d <= indicator;
      if (!rst && startup === 1'b1 && indicator !== ind_d) blinks <= blinks + 1;
      if (cyc == LIMIT) begin
         error_cnt++;
         stop_test();
      end
   end
   // ----
   // scenarios
   // ----
   initial begin
      logic [31:0] r;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      #1;
      `CHK("startup", 1'b1, startup)
      `CHK("detect", 1'b0, detect)
      // flags stay busy but must be ignored; stop short of the end so none straddles it
      while (cyc < 1850 * T) begin
         pulse(rnd() % 2 == 1, 5 * T);
         idle(50);
      end
      while (startup === 1'b1) idle(1);
      `CHK("start-up length", 1'b1, cyc inside {[1875 * T:1877 * T + 4]})
      // 1875 ticks at 15 ticks a half period; the last toggle gives way to the forced low
      `CHK("blinks", 1'b1, blinks inside {[123:125]})
      idle(2);
      `CHK("indicator after start-up", 1'b0, indicator)
      expect_hit();
      pulse(1'b1, 5 * T);
      idle(140 * T);
      indicator_enable_n <= 1'b1;
      idle(4);
      expect_hit();
      pulse(1'b0, 5 * T);
      idle(140 * T);
      for (int i = 0; i < 6; i++) begin
         r = rnd();
         indicator_enable_n <= r[2];
         idle(4);
         if (r[0]) expect_hit();
         // short ones see at most one tick
         pulse(r[1], r[0] ? 5 * T : 1 + r[5:4]);
         idle(140 * T);
      end
      mode <= 1'b1;
      indicator_enable_n <= 1'b0;
      idle(4);
      pulse(1'b1, 5 * T);
      idle(10 * T);
      expect_hit();
      pulse(1'b0, 5 * T);
      idle(140 * T);
      pulse(1'b1, 5 * T);
      idle(20 * T);
      pulse(1'b1, 5 * T);
      idle(320 * T);
      pulse(1'b0, 5 * T);
      idle(320 * T);
      pulse(1'b1, 5 * T);
      idle(320 * T);
      `CHK("pending", 0, exp_q.size())
      rst <= 1'b1;
      idle(3);
      rst <= 1'b0;
      #1;
      `CHK("startup again", 1'b1, startup)
      `CHK("indicator cleared", 1'b0, indicator)
      stop_test();
   end
endmodule // pir_motion_qualifier_test
`default_nettype wire
